/* core/dif_input_format.sv */
// input format stage of a dual-channel interpolating converter
`timescale 1ns/1ps
`default_nettype none
`include "dif_cfg.svh"

module dif_input_format #(
   parameter int SW = `DIF_SAMPLE_W,
   parameter int DEPTH = `DIF_FIFO_DEPTH
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rdata,
   // sample source
   input wire logic [SW-1:0] a_data,
   input wire logic [SW-1:0] b_data,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic second_input_clock,
   // sample sink
   output logic [SW-1:0] out_a,
   output logic [SW-1:0] out_b,
   output logic out_valid,
   input wire logic out_ready,
   // clock distribution controls
   output logic wr_clk_invert,
   output logic div_sync_pulse,
   output logic [1:0] interp_code
);

   localparam int LW = $clog2(DEPTH+1);

   // =====================================================
   // registers
   logic [7:0] cfg_reg;
   logic [7:0] act_reg;
   logic [7:0] rdata_reg;
   logic in_ready_reg;
   logic [SW-1:0] held_reg;
   logic sic_d_reg;
   logic div_sync_reg;
   logic inv_reg;
   logic [1:0] interp_reg;
   logic [SW-1:0] out_a_reg;
   logic [SW-1:0] out_b_reg;
   logic out_valid_reg;
   logic [2:0] rep_reg;
   dif_pkg::dif_state_e state_reg;
   dif_pkg::dif_state_e state_next;

   // =====================================================
   // active configuration fields
   wire dif_pkg::dif_insel_e act_insel = dif_pkg::dif_insel_e'(act_reg[`DIF_INSEL_HI:`DIF_INSEL_LO]);
   wire act_sync = act_reg[`DIF_SYNC_BIT];
   wire act_twos = act_reg[`DIF_TWOS_BIT];
   wire act_inv = act_reg[`DIF_INV_BIT];
   wire [1:0] act_interp = act_reg[`DIF_INTERP_HI:`DIF_INTERP_LO];

   // register decode
   wire cfg_hit = (addr == `DIF_ADDR_CONFIG);
   wire stat_hit = (addr == `DIF_ADDR_STATUS);
   wire cfg_wr = wr_en && cfg_hit;

   // format conversion to internal two's complement
   wire [SW-1:0] fa = act_twos ? a_data : {~a_data[SW-1], a_data[SW-2:0]};
   wire [SW-1:0] fb = act_twos ? b_data : {~b_data[SW-1], b_data[SW-2:0]};
   wire [SW-1:0] fsel = (act_insel == dif_pkg::DIF_IN_LEAVE_B) ? fb : fa;

   // fifo wiring
   logic push_valid;
   logic [2*SW-1:0] push_data;
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [2*SW-1:0] fifo_out_data;
   wire [LW-1:0] fifo_level;
   wire accept = in_valid && in_ready_reg;

   // interpolation output stage
   wire slot_free = !out_valid_reg || out_ready;
   wire pop = slot_free && (rep_reg == 3'h0) && fifo_out_valid;
   wire [2:0] rep_load = 3'((4'h1 << act_interp) - 4'h1);
   wire fill_zero = slot_free && (rep_reg != 3'h0);
   wire low_room = (fifo_level >= LW'(DEPTH-2));
   wire merge_push = (state_reg == dif_pkg::DIF_ST_MERGE) && fifo_in_ready;
   wire [7:0] status = {3'h0, fifo_level[LW-1:0] == '0, act_insel, state_reg != dif_pkg::DIF_ST_IDLE,
                        in_ready_reg};
   wire [7:0] rd_mux = cfg_hit ? cfg_reg : (stat_hit ? status : 8'h00);

   // =====================================================
   // input assembly, chooses what goes into the fifo
   always_comb begin
      state_next = state_reg;
      push_valid = 1'b0;
      push_data = {2*SW{1'b0}};
      unique case (state_reg)
         dif_pkg::DIF_ST_IDLE: begin
            if (accept) begin
               unique case (act_insel)
                  dif_pkg::DIF_IN_SEPARATE: begin
                     push_valid = 1'b1;
                     push_data = {fa, fb};
                  end
                  dif_pkg::DIF_IN_LEAVE_A, dif_pkg::DIF_IN_LEAVE_B: begin
                     state_next = dif_pkg::DIF_ST_PAIR;
                  end
                  dif_pkg::DIF_IN_MERGE: begin
                     push_valid = 1'b1;
                     push_data = {fa, {SW{1'b0}}};
                     state_next = dif_pkg::DIF_ST_MERGE;
                  end
               endcase
            end
         end
         dif_pkg::DIF_ST_PAIR: begin
            if (accept) begin
               push_valid = 1'b1;
               push_data = {held_reg, fsel};
               state_next = dif_pkg::DIF_ST_IDLE;
            end
         end
         dif_pkg::DIF_ST_MERGE: begin
            if (merge_push) begin
               push_valid = 1'b1;
               push_data = {held_reg, {SW{1'b0}}};
               state_next = dif_pkg::DIF_ST_IDLE;
            end
         end
      endcase
   end

   // config, active copy and assembly state
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cfg_reg <= `DIF_RST_CONFIG;
         act_reg <= `DIF_RST_CONFIG;
         state_reg <= dif_pkg::DIF_ST_IDLE;
         held_reg <= `DIF_RST_DATA;
         in_ready_reg <= 1'b0;
      end else begin
         if (cfg_wr) cfg_reg <= wdata;
         if (state_next == dif_pkg::DIF_ST_IDLE) act_reg <= cfg_reg;
         state_reg <= state_next;
         if (accept && state_reg == dif_pkg::DIF_ST_IDLE) held_reg <= (act_insel == dif_pkg::DIF_IN_MERGE) ? fb : fsel;
         in_ready_reg <= (state_next != dif_pkg::DIF_ST_MERGE) && !low_room;
      end
   end

   // read data, valid only in the cycle after the strobe
   always_ff @(posedge ref_clk) begin
      if (rst) rdata_reg <= 8'h00;
      else rdata_reg <= rd_en ? rd_mux : 8'h00;
   end

   // clock distribution controls
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sic_d_reg <= 1'b0;
         div_sync_reg <= 1'b0;
         inv_reg <= 1'b0;
         interp_reg <= 2'h0;
      end else begin
         sic_d_reg <= second_input_clock;
         div_sync_reg <= act_sync && second_input_clock && !sic_d_reg;
         inv_reg <= act_inv;
         interp_reg <= act_interp;
      end
   end

   // output stage, one sample then zero stuffing per interpolation step
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         out_a_reg <= `DIF_RST_DATA;
         out_b_reg <= `DIF_RST_DATA;
         out_valid_reg <= 1'b0;
         rep_reg <= 3'h0;
      end else if (pop) begin
         out_a_reg <= fifo_out_data[2*SW-1:SW];
         out_b_reg <= fifo_out_data[SW-1:0];
         out_valid_reg <= 1'b1;
         rep_reg <= rep_load;
      end else if (fill_zero) begin
         out_a_reg <= `DIF_RST_DATA;
         out_b_reg <= `DIF_RST_DATA;
         out_valid_reg <= 1'b1;
         rep_reg <= rep_reg - 3'h1;
      end else if (slot_free) begin
         out_valid_reg <= 1'b0;
      end
   end

   // sample buffer between assembly and output stage
   dif_fifo #(
      .WIDTH(2*SW),
      .DEPTH(DEPTH)
   ) u_fifo (
      .ref_clk(ref_clk),
      .rst(rst),
      .in_valid(push_valid),
      .in_ready(fifo_in_ready),
      .in_data(push_data),
      .out_valid(fifo_out_valid),
      .out_ready(pop),
      .out_data(fifo_out_data),
      .level(fifo_level)
   );

   // port drives
   assign rdata = rdata_reg;
   assign in_ready = in_ready_reg;
   assign out_a = out_a_reg;
   assign out_b = out_b_reg;
   assign out_valid = out_valid_reg;
   assign wr_clk_invert = inv_reg;
   assign div_sync_pulse = div_sync_reg;
   assign interp_code = interp_reg;

   // =====================================================
   // assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence merge_first;
      state_reg == dif_pkg::DIF_ST_IDLE && act_insel == dif_pkg::DIF_IN_MERGE && accept;
   endsequence

   sequence merge_second;
      state_reg == dif_pkg::DIF_ST_MERGE ##[0:8] (push_valid && push_data[SW-1:0] == {SW{1'b0}});
   endsequence

   mode_sep_a: assert property (
      (state_reg == dif_pkg::DIF_ST_IDLE && act_insel == dif_pkg::DIF_IN_SEPARATE && accept)
      |-> push_valid && push_data == {fa, fb})
      else $error("separate mode did not push both ports");

   merge_pair_a: assert property (merge_first |-> push_valid ##1 merge_second)
      else $error("merge mode did not push two samples");

   leave_pair_a: assert property (
      (state_reg == dif_pkg::DIF_ST_PAIR && accept) |-> push_valid && push_data[2*SW-1:SW] == held_reg)
      else $error("interleave pair lost its first sample");

   sync_pulse_a: assert property (
      (act_sync && second_input_clock && !sic_d_reg) |=> div_sync_pulse)
      else $error("divider sync pulse missing");

   fmt_offset_a: assert property (!act_twos |-> fa == (a_data ^ {1'b1, {SW-1{1'b0}}}))
      else $error("offset binary not converted");

   inv_clk_a: assert property (1'b1 |=> wr_clk_invert == $past(act_inv))
      else $error("write clock inversion not following setting");

   interp_one_a: assert property ((pop && act_interp == 2'h0) |=> rep_reg == 3'h0 && out_valid)
      else $error("factor one inserted extra samples");

   cfg_hold_a: assert property ((state_reg != dif_pkg::DIF_ST_IDLE && state_next != dif_pkg::DIF_ST_IDLE)
      |=> $stable(act_reg))
      else $error("configuration changed inside a sample pair");

   rd_once_a: assert property (!rd_en |=> rdata == 8'h00)
      else $error("read data stood outside its cycle");

   // sink holding, zero stuffing and interpolation code
   out_hold_a: assert property (
      (out_valid && !out_ready) |=> out_valid && $stable(out_a) && $stable(out_b))
      else $error("output pair changed while stalled");

   zero_stuff_a: assert property (
      fill_zero |=> out_valid && out_a == {SW{1'b0}} && out_b == {SW{1'b0}})
      else $error("stuffed sample was not zero");

   interp_code_a: assert property (1'b1 |=> interp_code == $past(act_interp))
      else $error("interpolation code not following setting");

   // input side pacing and buffer safety
   merge_ready_a: assert property (merge_first |=> !in_ready)
      else $error("merge mode accepted during second word");

   fifo_safe_a: assert property (push_valid |-> fifo_in_ready)
      else $error("sample pushed into a full buffer");

   leave_hold_a: assert property (
      (state_reg == dif_pkg::DIF_ST_PAIR && !accept) |=> state_reg == dif_pkg::DIF_ST_PAIR)
      else $error("interleave pair dropped its first half");

   // settings reach the datapath through the active copy
   act_apply_a: assert property (
      state_next == dif_pkg::DIF_ST_IDLE |=> act_reg == $past(cfg_reg))
      else $error("active settings not refreshed while idle");

   sync_only_a: assert property (!act_sync |=> !div_sync_pulse)
      else $error("divider sync pulse without sync mode");

   twos_pass_a: assert property (act_twos |-> fa == a_data && fb == b_data)
      else $error("two's complement samples were altered");

endmodule
`default_nettype wire

/* core/dif_cfg.svh */
// register map, field positions, reset values and sizes of the input format block
`ifndef DIF_CFG_SVH
`define DIF_CFG_SVH

// =====================================================
// register offsets
`define DIF_ADDR_CONFIG 8'h01
`define DIF_ADDR_STATUS 8'h10

// =====================================================
// configuration register fields
`define DIF_INSEL_HI 7
`define DIF_INSEL_LO 6
`define DIF_SYNC_BIT 4
`define DIF_TWOS_BIT 3
`define DIF_INV_BIT 2
`define DIF_INTERP_HI 1
`define DIF_INTERP_LO 0

// =====================================================
// reset values
`define DIF_RST_CONFIG 8'h0B
`define DIF_RST_DATA 16'h0000

// =====================================================
// sizes
`define DIF_SAMPLE_W 16
`define DIF_FIFO_DEPTH 8

`endif

/* core/dif_pkg.sv */
// types shared by the input format block
package dif_pkg;

   // =====================================================
   // input arrangement codes
   typedef enum logic [1:0] {
      DIF_IN_SEPARATE = 2'h0,
      DIF_IN_LEAVE_A = 2'h1,
      DIF_IN_LEAVE_B = 2'h2,
      DIF_IN_MERGE = 2'h3
   } dif_insel_e;

   // =====================================================
   // input assembly states, one-hot
   typedef enum logic [2:0] {
      DIF_ST_IDLE = 3'b001,
      DIF_ST_PAIR = 3'b010,
      DIF_ST_MERGE = 3'b100
   } dif_state_e;

endpackage

/* core/dif_fifo.sv */
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module dif_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst,
   // filling side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // fill level
   output logic [$clog2(DEPTH+1)-1:0] level
);

   localparam int AW = $clog2(DEPTH);
   localparam int LW = $clog2(DEPTH+1);

   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [LW-1:0] cnt_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // honest flags from the count
   assign in_ready = (cnt_reg != LW'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem_reg[rd_ptr_reg];
   assign level = cnt_reg;

   // pointer and count update
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
         if (pop) rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
         cnt_reg <= cnt_reg + LW'(push) - LW'(pop);
      end
   end

   // storage write
   always_ff @(posedge ref_clk) begin
      if (push) mem_reg[wr_ptr_reg] <= in_data;
   end

endmodule
`default_nettype wire

/* verification/dif_src_model.sv */
// parallel sample source model feeding the input format stage
`timescale 1ns/1ps
`default_nettype none

module dif_src_model (
   // clock
   input wire logic ref_clk,
   // sample bus
   output logic [15:0] a_data,
   output logic [15:0] b_data,
   output logic in_valid,
   input wire logic in_ready
);
   logic [31:0] q[$];
   int seed = 88;

   // queue one beat, offered until taken
   task automatic send(input logic [15:0] a, input logic [15:0] b);
      q.push_back({a, b});
   endtask

   initial begin
      in_valid = 1'b0;
      a_data = 16'hA5A5;
      b_data = 16'h5A5A;
   end

   // hold a beat until accepted, stall at random, scramble bus when idle
   always @(posedge ref_clk) begin
      if (in_valid && in_ready)
         void'(q.pop_front());
      if (in_valid && !in_ready) begin
      end else if (q.size() > 0 && ($random(seed) & 3) != 0) begin
         in_valid <= 1'b1;
         {a_data, b_data} <= q[0];
      end else begin
         in_valid <= 1'b0;
         a_data <= ~a_data;
         b_data <= ~b_data;
      end
   end
endmodule

`default_nettype wire

/* verification/tb.sv */
// self-checking bench of the input format stage
`timescale 1ns/1ps
`default_nettype none
`include "dif_cfg.svh"

module tb;
   logic ref_clk = 1'b0, rst = 1'b1, wr_en = 1'b0, rd_en = 1'b0, out_ready = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
   logic [15:0] a_data, b_data, out_a, out_b;
   logic in_valid, in_ready, out_valid, wr_clk_invert, div_sync_pulse, second_input_clock = 1'b0;
   logic [1:0] interp_code, cur_ip;
   logic [31:0] exp_q[$];
   logic hold_sink = 1'b0;
   int seed = 88, n_mismatch = 0, checks = 0, cycles = 0, n_pulse = 0;

   // 40 MHz clock
   always #12.5 ref_clk = ~ref_clk;

   dif_input_format u_dut (.ref_clk(ref_clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .a_data(a_data), .b_data(b_data), .in_valid(in_valid),
      .in_ready(in_ready), .second_input_clock(second_input_clock), .out_a(out_a), .out_b(out_b),
      .out_valid(out_valid), .out_ready(out_ready), .wr_clk_invert(wr_clk_invert),
      .div_sync_pulse(div_sync_pulse), .interp_code(interp_code));

   dif_src_model u_src (.ref_clk(ref_clk), .a_data(a_data), .b_data(b_data), .in_valid(in_valid),
      .in_ready(in_ready));

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // hang guard
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles > 20000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   // random sink with compare against expected words
   always @(posedge ref_clk) begin
      out_ready <= hold_sink ? 1'b0 : 1'(($random(seed) & 3) != 0);
      if (!rst && out_valid === 1'b1 && out_ready)
         check({out_a, out_b}, exp_q.size() > 0 ? exp_q.pop_front() : ~{out_a, out_b});
   end

   // divider sync pulse counter
   always @(posedge ref_clk) begin
      if (div_sync_pulse === 1'b1)
         n_pulse++;
   end

   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge ref_clk);
      wr_en <= 1'b1;
      addr <= ad;
      wdata <= d;
      @(posedge ref_clk);
      wr_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
      @(posedge ref_clk);
      rd_en <= 1'b1;
      addr <= ad;
      @(posedge ref_clk);
      rd_en <= 1'b0;
      @(negedge ref_clk);
      check({24'h0, rdata}, {24'h0, exp});
   endtask

   // sample as the stage should deliver it
   function automatic logic [15:0] cv(input logic [15:0] x, input logic tw);
      return tw ? x : {~x[15], x[14:0]};
   endfunction

   // one word then the zero-stuffed pairs
   function automatic void push_exp(input logic [15:0] a, input logic [15:0] b);
      exp_q.push_back({a, b});
      repeat ((1 << cur_ip) - 1) exp_q.push_back(32'h0);
   endfunction

   task automatic drain();
      int k;
      for (k = 0; k < 3000 && (exp_q.size() > 0 || u_src.q.size() > 0); k++)
         @(posedge ref_clk);
      check(exp_q.size(), 0);
   endtask

   task automatic run_mode(input logic [1:0] sel, input logic tw, input logic [1:0] ip, input int n);
      logic [15:0] a, b, held;
      int i;
      cur_ip = ip;
      wr(`DIF_ADDR_CONFIG, {sel, 2'h0, tw, ip[0], ip});
      rd(`DIF_ADDR_CONFIG, {sel, 2'h0, tw, ip[0], ip});
      check({30'h0, interp_code}, {30'h0, ip});
      check({31'h0, wr_clk_invert}, {31'h0, ip[0]});
      rd(`DIF_ADDR_STATUS, {3'h0, 1'b1, sel, 2'h1});
      for (i = 0; i < n; i++) begin
         a = 16'($random(seed));
         b = (i == 0) ? 16'h8000 : 16'($random(seed));
         u_src.send(a, b);
         case (sel)
            2'h0: push_exp(cv(a, tw), cv(b, tw));
            2'h1: if (i % 2) push_exp(held, cv(a, tw)); else held = cv(a, tw);
            2'h2: if (i % 2) push_exp(held, cv(b, tw)); else held = cv(b, tw);
            default: begin
               push_exp(cv(a, tw), 16'h0);
               push_exp(cv(b, tw), 16'h0);
            end
         endcase
      end
      drain();
      $display("mode %0d twos %0d interp %0d done", sel, tw, ip);
   endtask

   task automatic toggle_sic(input int n);
      repeat (n) begin
         repeat (3) @(posedge ref_clk);
         second_input_clock <= 1'b1;
         repeat (3) @(posedge ref_clk);
         second_input_clock <= 1'b0;
      end
      repeat (6) @(posedge ref_clk);
   endtask

   // main sequence
   initial begin
      int i;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      rd(`DIF_ADDR_CONFIG, `DIF_RST_CONFIG);
      rd(`DIF_ADDR_STATUS, 8'h11);
      rd(8'h20, 8'h00);
      wr(`DIF_ADDR_STATUS, 8'hFF);
      rd(`DIF_ADDR_CONFIG, `DIF_RST_CONFIG);
      $display("register test done");
      for (i = 0; i < 4; i++)
         run_mode(2'(i), 1'b1, 2'h0, 16);
      run_mode(2'h0, 1'b0, 2'h0, 16);
      run_mode(2'h1, 1'b0, 2'h1, 16);
      run_mode(2'h3, 1'b1, 2'h2, 8);
      run_mode(2'h2, 1'b1, 2'h3, 8);
      hold_sink = 1'b1;
      run_mode(2'h0, 1'b1, 2'h0, 0);
      for (i = 0; i < 12; i++) begin
         u_src.send(16'(i), 16'(~i));
         push_exp(16'(i), 16'(~i));
      end
      repeat (40) @(posedge ref_clk);
      check({31'h0, in_ready}, 32'h0);
      hold_sink = 1'b0;
      drain();
      $display("fifo fill test done");
      wr(`DIF_ADDR_CONFIG, 8'h18);
      n_pulse = 0;
      toggle_sic(4);
      check(n_pulse, 4);
      wr(`DIF_ADDR_CONFIG, 8'h08);
      n_pulse = 0;
      toggle_sic(4);
      check(n_pulse, 0);
      $display("sync test done");
      report_and_stop();
   end
endmodule

`default_nettype wire
